// file: include/ldr_decision_map.vh
// Register map, field positions, reset values and timing counts of the decision block
`ifndef LDR_DECISION_MAP_VH
`define LDR_DECISION_MAP_VH

// ****************************************
// Register byte offsets
// ****************************************
`define LDR_OFS_CTRL 6'h00
`define LDR_OFS_H2THR 6'h04
`define LDR_OFS_H5THR 6'h08
`define LDR_OFS_BASE 6'h0C
`define LDR_OFS_SLOPE 6'h10
`define LDR_OFS_UNRLIM 6'h14
`define LDR_OFS_TXBITS 6'h18
`define LDR_OFS_RXBITS 6'h1C
`define LDR_OFS_STATUS 6'h20
`define LDR_OFS_IRQSTAT 6'h24
`define LDR_OFS_IRQMASK 6'h28

// ****************************************
// Field positions
// ****************************************
`define LDR_CTRL_ENABLE 0
`define LDR_ST_TRIP_LSB 0
`define LDR_ST_GENTRIP 3
`define LDR_ST_HARMONIC_BLOCK_FLAG 4
`define LDR_ST_H2GEN 5
`define LDR_ST_H5GEN 6
`define LDR_ST_UNRGEN 7
`define LDR_ST_LINKFAIL 8
`define LDR_IRQ_TRIP 0
`define LDR_IRQ_HARM 1
`define LDR_IRQ_LINK 2
`define LDR_IRQ_W 3

// ****************************************
// Reset values
// ****************************************
`define LDR_RST_CTRL 1'h1
`define LDR_RST_H2THR 8'h0F
`define LDR_RST_H5THR 8'h19
`define LDR_RST_BASE 17'h00400
`define LDR_RST_SLOPE 8'h40
`define LDR_RST_UNRLIM 17'h08000

// ****************************************
// Timing
// ****************************************
`define LDR_CLK_MHZ 100
`define LDR_TICK_US 1000
`define LDR_PICKUP_MS 25
`define LDR_DROPOFF_MS 15
`define LDR_LINK_TIMEOUT_MS 20
`define LDR_PCT_SCALE 100

`endif

// file: logic/ldr_decision.v
// Line differential restraint and trip decision with Avalon-MM registers
`timescale 1ns/1ps
`default_nettype none
`include "ldr_decision_map.vh"

module ldr_decision #(
    parameter TICK_CYCLES = `LDR_TICK_US * `LDR_CLK_MHZ // Cycles per evaluation tick
) (
    input wire clk_sys, // System clock, 100 MHz
    input wire rstn, // Synchronous reset, active low
    input wire [5:0] avs_address, // Avalon byte address
    input wire avs_read, // Avalon read
    input wire avs_write, // Avalon write
    input wire [31:0] avs_writedata, // Avalon write data
    output reg [31:0] avs_readdata, // Avalon read data
    output wire avs_waitrequest, // Avalon wait request
    input wire [47:0] diffFundRe, // Differential fundamental, real, 3x16
    input wire [47:0] diffFundIm, // Differential fundamental, imaginary
    input wire [47:0] diffH2Re, // Differential 2nd harmonic, real
    input wire [47:0] diffH2Im, // Differential 2nd harmonic, imaginary
    input wire [47:0] diffH5Re, // Differential 5th harmonic, real
    input wire [47:0] diffH5Im, // Differential 5th harmonic, imaginary
    input wire [47:0] localShiftedRe, // Local shifted currents, real
    input wire [47:0] localShiftedIm, // Local shifted currents, imaginary
    input wire [47:0] remoteShiftedRe, // Remote shifted currents, real
    input wire [47:0] remoteShiftedIm, // Remote shifted currents, imaginary
    input wire functionBlockInput, // User block, high disables
    input wire [11:0] txConfigBit, // Local bits to send
    output reg [11:0] linkTxBits_ff, // Bits to link transmitter
    output reg linkTxValid_ff, // Transmit strobe, one cycle per tick
    input wire [11:0] linkRxBits, // Bits from link receiver
    input wire linkRxValid, // Receive strobe
    output reg [11:0] rxConfigBit_ff, // Received remote bits
    output reg [2:0] phaseTrip_ff, // Trip per phase
    output reg generalTrip_ff, // General trip
    output reg harmonicBlockFlag_ff, // Harmonic blocking
    output reg [2:0] harm2Restrain, // Second harmonic restraint per phase
    output reg [2:0] harm5Restrain, // Fifth harmonic restraint per phase
    output reg linkFailureFlag_ff, // Remote data stopped
    output wire irq // Interrupt, level
);
    localparam integer LINK_TICKS = `LDR_LINK_TIMEOUT_MS * 1000 / `LDR_TICK_US;

    // ****************************************
    // Evaluation tick divider
    // ****************************************
    reg [31:0] div_ff;
    reg tick_ff;

    always @(posedge clk_sys) begin
        if (!rstn) begin
            div_ff <= 32'h00000000;
            tick_ff <= 1'b0;
        end else if (div_ff == TICK_CYCLES - 1) begin
            div_ff <= 32'h00000000;
            tick_ff <= 1'b1;
        end else begin
            div_ff <= div_ff + 32'h00000001;
            tick_ff <= 1'b0;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    reg ctrlEnable_ff;
    reg [7:0] h2Thr_ff;
    reg [7:0] h5Thr_ff;
    reg [16:0] baseThr_ff;
    reg [7:0] slope_ff;
    reg [16:0] unrLimit_ff;
    reg [2:0] irqStat_ff;
    reg [2:0] irqMask_ff;
    reg ack_ff;
    reg [2:0] restrStart_ff;
    reg [2:0] unrStart_ff;
    reg [31:0] nxt_readdata;
    wire [2:0] irqEvent;
    wire wrStb;
    wire [2:0] restr2;
    wire [2:0] restr5;

    // One wait cycle per access, answer in the second cycle
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
    assign wrStb = avs_write & ack_ff;
    assign irq = |(irqStat_ff & irqMask_ff);

    always @* begin
        nxt_readdata = 32'h00000000;
        case (avs_address)
            `LDR_OFS_CTRL: nxt_readdata[`LDR_CTRL_ENABLE] = ctrlEnable_ff;
            `LDR_OFS_H2THR: nxt_readdata[7:0] = h2Thr_ff;
            `LDR_OFS_H5THR: nxt_readdata[7:0] = h5Thr_ff;
            `LDR_OFS_BASE: nxt_readdata[16:0] = baseThr_ff;
            `LDR_OFS_SLOPE: nxt_readdata[7:0] = slope_ff;
            `LDR_OFS_UNRLIM: nxt_readdata[16:0] = unrLimit_ff;
            `LDR_OFS_TXBITS: nxt_readdata[11:0] = linkTxBits_ff;
            `LDR_OFS_RXBITS: nxt_readdata[11:0] = rxConfigBit_ff;
            `LDR_OFS_STATUS: begin
                nxt_readdata[`LDR_ST_TRIP_LSB+2:`LDR_ST_TRIP_LSB] = phaseTrip_ff;
                nxt_readdata[`LDR_ST_GENTRIP] = generalTrip_ff;
                nxt_readdata[`LDR_ST_HARMONIC_BLOCK_FLAG] = harmonicBlockFlag_ff;
                nxt_readdata[`LDR_ST_H2GEN] = |harm2Restrain;
                nxt_readdata[`LDR_ST_H5GEN] = |harm5Restrain;
                nxt_readdata[`LDR_ST_UNRGEN] = |unrStart_ff;
                nxt_readdata[`LDR_ST_LINKFAIL] = linkFailureFlag_ff;
            end
            `LDR_OFS_IRQSTAT: nxt_readdata[`LDR_IRQ_W-1:0] = irqStat_ff;
            `LDR_OFS_IRQMASK: nxt_readdata[`LDR_IRQ_W-1:0] = irqMask_ff;
            default: nxt_readdata = 32'h00000000;
        endcase
    end

    always @(posedge clk_sys) begin
        if (!rstn) begin
            ack_ff <= 1'b0;
            avs_readdata <= 32'h00000000;
            ctrlEnable_ff <= `LDR_RST_CTRL;
            h2Thr_ff <= `LDR_RST_H2THR;
            h5Thr_ff <= `LDR_RST_H5THR;
            baseThr_ff <= `LDR_RST_BASE;
            slope_ff <= `LDR_RST_SLOPE;
            unrLimit_ff <= `LDR_RST_UNRLIM;
            irqMask_ff <= 3'h0;
            irqStat_ff <= 3'h0;
        end else begin
            ack_ff <= (avs_read | avs_write) & ~ack_ff;
            if (avs_read & ~ack_ff)
                avs_readdata <= nxt_readdata;
            if (wrStb) begin
                case (avs_address)
                    `LDR_OFS_CTRL: ctrlEnable_ff <= avs_writedata[`LDR_CTRL_ENABLE];
                    `LDR_OFS_H2THR: h2Thr_ff <= avs_writedata[7:0];
                    `LDR_OFS_H5THR: h5Thr_ff <= avs_writedata[7:0];
                    `LDR_OFS_BASE: baseThr_ff <= avs_writedata[16:0];
                    `LDR_OFS_SLOPE: slope_ff <= avs_writedata[7:0];
                    `LDR_OFS_UNRLIM: unrLimit_ff <= avs_writedata[16:0];
                    `LDR_OFS_IRQMASK: irqMask_ff <= avs_writedata[`LDR_IRQ_W-1:0];
                    default: ;
                endcase
            end
            // Set beats write-one-to-clear in the same cycle
            if (wrStb && avs_address == `LDR_OFS_IRQSTAT)
                irqStat_ff <= (irqStat_ff & ~avs_writedata[`LDR_IRQ_W-1:0]) | irqEvent;
            else
                irqStat_ff <= irqStat_ff | irqEvent;
        end
    end

    // ****************************************
    // Magnitudes and harmonic restraint per phase
    // ****************************************
    wire [16:0] diffMag [0:2];
    wire [16:0] locMag [0:2];
    wire [16:0] remMag [0:2];
    wire [16:0] h2Mag [0:2];
    wire [16:0] h5Mag [0:2];
    wire [2:0] ratio2High;
    wire [2:0] ratio5High;

    genvar ph;
    generate
        for (ph = 0; ph < 3; ph = ph + 1) begin : gPhase
            ldr_magnitude uDiff (
                .re(diffFundRe[16*ph+15:16*ph]),
                .im(diffFundIm[16*ph+15:16*ph]),
                .mag(diffMag[ph])
            );
            ldr_magnitude uLoc (
                .re(localShiftedRe[16*ph+15:16*ph]),
                .im(localShiftedIm[16*ph+15:16*ph]),
                .mag(locMag[ph])
            );
            ldr_magnitude uRem (
                .re(remoteShiftedRe[16*ph+15:16*ph]),
                .im(remoteShiftedIm[16*ph+15:16*ph]),
                .mag(remMag[ph])
            );
            ldr_magnitude uH2 (
                .re(diffH2Re[16*ph+15:16*ph]),
                .im(diffH2Im[16*ph+15:16*ph]),
                .mag(h2Mag[ph])
            );
            ldr_magnitude uH5 (
                .re(diffH5Re[16*ph+15:16*ph]),
                .im(diffH5Im[16*ph+15:16*ph]),
                .mag(h5Mag[ph])
            );
            // Ratio in percent compared without a divider
            assign ratio2High[ph] = ({8'h00, h2Mag[ph]} * 32'd`LDR_PCT_SCALE)
                > ({24'h000000, h2Thr_ff} * {15'h0000, diffMag[ph]});
            assign ratio5High[ph] = ({8'h00, h5Mag[ph]} * 32'd`LDR_PCT_SCALE)
                > ({24'h000000, h5Thr_ff} * {15'h0000, diffMag[ph]});
            ldr_harm_restraint uR2 (
                .clk_sys(clk_sys),
                .rstn(rstn),
                .tick(tick_ff),
                .ratioHigh(ratio2High[ph]),
                .restrain_ff(restr2[ph])
            );
            ldr_harm_restraint uR5 (
                .clk_sys(clk_sys),
                .rstn(rstn),
                .tick(tick_ff),
                .ratioHigh(ratio5High[ph]),
                .restrain_ff(restr5[ph])
            );
        end
    endgenerate

    always @* begin
        harm2Restrain = restr2;
        harm5Restrain = restr5;
    end

    // ****************************************
    // Bias and differential characteristic
    // ****************************************
    reg [16:0] biasMag;
    reg [25:0] slopeTerm;
    reg [17:0] restrThr;
    integer k;

    always @* begin
        biasMag = 17'h00000;
        for (k = 0; k < 3; k = k + 1) begin
            if (locMag[k] > biasMag)
                biasMag = locMag[k];
            if (remMag[k] > biasMag)
                biasMag = remMag[k];
        end
        // Slope in 1/256 steps on top of the base level
        slopeTerm = {9'h000, biasMag} * {18'h00000, slope_ff};
        restrThr = {1'b0, baseThr_ff} + {1'b0, slopeTerm[24:8]};
    end

    wire [2:0] phaseTripNow;
    wire harmAny;
    wire tripAllowed;

    assign harmAny = (|restr2) | (|restr5);
    // Stale remote data must not trip; user block has precedence
    assign tripAllowed = ctrlEnable_ff & ~functionBlockInput & ~linkFailureFlag_ff;
    assign phaseTripNow = ((restrStart_ff & {3{~harmAny}}) | unrStart_ff)
        & {3{tripAllowed}};

    genvar sp;
    generate
        for (sp = 0; sp < 3; sp = sp + 1) begin : gStart
            always @(posedge clk_sys) begin
                if (!rstn) begin
                    restrStart_ff[sp] <= 1'b0;
                    unrStart_ff[sp] <= 1'b0;
                end else if (tick_ff) begin
                    restrStart_ff[sp] <= {1'b0, diffMag[sp]} > restrThr;
                    unrStart_ff[sp] <= diffMag[sp] > unrLimit_ff;
                end
            end
        end
    endgenerate

    // ****************************************
    // Outputs, link bits and link supervision
    // ****************************************
    reg [15:0] silent_ff;

    assign irqEvent[`LDR_IRQ_TRIP] = (|phaseTripNow) & ~generalTrip_ff;
    assign irqEvent[`LDR_IRQ_HARM] = harmAny & ~harmonicBlockFlag_ff;
    assign irqEvent[`LDR_IRQ_LINK] = (silent_ff >= LINK_TICKS) & ~linkFailureFlag_ff;

    always @(posedge clk_sys) begin
        if (!rstn) begin
            phaseTrip_ff <= 3'h0;
            generalTrip_ff <= 1'b0;
            harmonicBlockFlag_ff <= 1'b0;
            linkTxBits_ff <= 12'h000;
            linkTxValid_ff <= 1'b0;
            rxConfigBit_ff <= 12'h000;
            silent_ff <= 16'h0000;
            linkFailureFlag_ff <= 1'b0;
        end else begin
            phaseTrip_ff <= phaseTripNow;
            generalTrip_ff <= |phaseTripNow;
            harmonicBlockFlag_ff <= harmAny;
            linkTxValid_ff <= tick_ff;
            if (tick_ff)
                linkTxBits_ff <= txConfigBit;
            if (linkRxValid)
                rxConfigBit_ff <= linkRxBits;
            if (linkRxValid)
                silent_ff <= 16'h0000;
            else if (tick_ff && silent_ff != LINK_TICKS)
                silent_ff <= silent_ff + 16'h0001;
            linkFailureFlag_ff <= silent_ff >= LINK_TICKS;
        end
    end
endmodule

`default_nettype wire

// file: logic/ldr_harm_restraint.v
// Harmonic restraint status of one phase and one harmonic order
`timescale 1ns/1ps
`default_nettype none
`include "ldr_decision_map.vh"

module ldr_harm_restraint (
    input wire clk_sys, // System clock
    input wire rstn, // Synchronous reset, active low
    input wire tick, // Evaluation tick
    input wire ratioHigh, // Harmonic ratio above threshold
    output reg restrain_ff // Restraint status
);
    localparam integer PICK_TICKS = `LDR_PICKUP_MS * 1000 / `LDR_TICK_US;
    localparam integer DROP_TICKS = `LDR_DROPOFF_MS * 1000 / `LDR_TICK_US;

    reg [5:0] pick_ff;
    reg [5:0] drop_ff;

    always @(posedge clk_sys) begin
        if (!rstn) begin
            restrain_ff <= 1'b0;
            pick_ff <= 6'h00;
            drop_ff <= 6'h00;
        end else if (tick) begin
            if (ratioHigh) begin
                restrain_ff <= 1'b1;
                drop_ff <= 6'h00;
                // A return during stretch starts a fresh continuous run
                if (drop_ff != 6'h00)
                    pick_ff <= 6'h01;
                else if (pick_ff != PICK_TICKS)
                    pick_ff <= pick_ff + 6'h01;
            end else if (pick_ff == PICK_TICKS && drop_ff != DROP_TICKS) begin
                restrain_ff <= 1'b1;
                drop_ff <= drop_ff + 6'h01;
            end else begin
                restrain_ff <= 1'b0;
                pick_ff <= 6'h00;
                drop_ff <= 6'h00;
            end
        end
    end
endmodule

`default_nettype wire

// file: logic/ldr_magnitude.v
// Magnitude approximation of one Fourier vector
`timescale 1ns/1ps
`default_nettype none

module ldr_magnitude (
    input wire signed [15:0] re, // Real part
    input wire signed [15:0] im, // Imaginary part
    output wire [16:0] mag // Approximate magnitude
);
    wire [16:0] absRe;
    wire [16:0] absIm;
    wire [16:0] hiVal;
    wire [16:0] loVal;

    // Max plus half min: within about 12 percent, no multiplier or root needed
    assign absRe = re[15] ? (17'h00000 - {re[15], re}) : {1'b0, re};
    assign absIm = im[15] ? (17'h00000 - {im[15], im}) : {1'b0, im};
    assign hiVal = (absRe > absIm) ? absRe : absIm;
    assign loVal = (absRe > absIm) ? absIm : absRe;
    assign mag = hiVal + {1'b0, loVal[16:1]};
endmodule

`default_nettype wire

// file: sim/ldr_decision_assertions.sv
// Port checker for the restraint and trip decision block
`timescale 1ns/1ps
`default_nettype none
module ldr_decision_assertions #(
    parameter TICK_CYCLES = 10 // Cycles per evaluation tick
) (
    input wire logic clk_sys, // Clock
    input wire logic rstn, // Reset, active low
    input wire logic avs_read, // Bus read
    input wire logic avs_write, // Bus write
    input wire logic avs_waitrequest, // Bus wait
    input wire logic functionBlockInput, // User block
    input wire logic [11:0] txConfigBit, // Local bits
    input wire logic [11:0] linkTxBits_ff, // Sent bits
    input wire logic linkTxValid_ff, // Send strobe
    input wire logic [11:0] linkRxBits, // Received bits
    input wire logic linkRxValid, // Receive strobe
    input wire logic [11:0] rxConfigBit_ff, // Presented bits
    input wire logic [2:0] phaseTrip_ff, // Phase trips
    input wire logic generalTrip_ff, // General trip
    input wire logic harmonicBlockFlag_ff, // Harmonic block
    input wire logic [2:0] harm2Restrain, // Second order restraint
    input wire logic [2:0] harm5Restrain, // Fifth order restraint
    input wire logic linkFailureFlag_ff // Link failure
);
    logic [15:0] gapCnt_ff;
    logic [15:0] quietCnt_ff;
    logic seenTx_ff;
    // ****************************************
    // Cycle counters
    // ****************************************
    always @(posedge clk_sys) begin
        if (!rstn) begin
            gapCnt_ff <= 16'h0000;
            quietCnt_ff <= 16'h0000;
            seenTx_ff <= 1'b0;
        end else begin
            gapCnt_ff <= linkTxValid_ff ? 16'h0000 : gapCnt_ff + 16'h0001;
            seenTx_ff <= seenTx_ff | linkTxValid_ff;
            if (linkRxValid) begin
                quietCnt_ff <= 16'h0000;
            end else if (quietCnt_ff != 16'hFFFF) begin
                quietCnt_ff <= quietCnt_ff + 16'h0001;
            end
        end
    end
    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence sNewReq;
        $rose(avs_read || avs_write);
    endsequence
    sequence sWaitOne;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    property pBus;
        sNewReq |-> sWaitOne;
    endproperty
    chk_bus_wait: assert property (pBus) else $error("bus answer not after one wait");
    chk_gen_or: assert property (generalTrip_ff == (|phaseTrip_ff))
        else $error("general trip differs from phase trips");
    chk_block_trip: assert property (functionBlockInput && $past(functionBlockInput)
        |-> phaseTrip_ff == 3'h0) else $error("trip while blocked");
    chk_harm_or: assert property (harmonicBlockFlag_ff ==
        $past((|harm2Restrain) || (|harm5Restrain))) else $error("harmonic block wrong");
    chk_tx_pulse: assert property (linkTxValid_ff |=> !linkTxValid_ff)
        else $error("send strobe too long");
    chk_tx_gap: assert property (linkTxValid_ff && seenTx_ff |->
        gapCnt_ff == TICK_CYCLES - 1) else $error("send strobe off tick");
    chk_tx_bits: assert property (linkTxValid_ff && txConfigBit == $past(txConfigBit)
        && txConfigBit == $past(txConfigBit, 2) |-> linkTxBits_ff == txConfigBit)
        else $error("sent bits differ");
    chk_rx_take: assert property (linkRxValid |=> rxConfigBit_ff == $past(linkRxBits))
        else $error("received bits not presented");
    chk_link_clear: assert property (linkRxValid |-> ##[1:2] !linkFailureFlag_ff)
        else $error("link failure not cleared");
    chk_link_early: assert property ($rose(linkFailureFlag_ff) |->
        quietCnt_ff >= 19 * TICK_CYCLES) else $error("link failure too early");
    chk_link_late: assert property (quietCnt_ff == 22 * TICK_CYCLES |->
        linkFailureFlag_ff) else $error("link failure missing");
endmodule
bind ldr_decision ldr_decision_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .clk_sys, .rstn, .avs_read, .avs_write, .avs_waitrequest, .functionBlockInput,
    .txConfigBit, .linkTxBits_ff, .linkTxValid_ff, .linkRxBits, .linkRxValid,
    .rxConfigBit_ff, .phaseTrip_ff, .generalTrip_ff, .harmonicBlockFlag_ff,
    .harm2Restrain, .harm5Restrain, .linkFailureFlag_ff
);
`default_nettype wire

// file: sim/ldr_link_partner.sv
// Remote relay model: echoes the sent bits back over the link
`timescale 1ns/1ps
`default_nettype none
module ldr_link_partner (
    input wire logic clk_sys, // Clock
    input wire logic rstn, // Reset, active low
    input wire logic [11:0] txBits, // Bits from the block
    input wire logic txValid, // Send strobe
    input wire logic silent, // Stop answering
    input wire logic slow, // Answer late
    output logic [11:0] rxBits, // Bits to the block
    output logic rxValid // Receive strobe
);
    logic [11:0] held_ff;
    logic [3:0] delay_ff;
    always @(posedge clk_sys) begin
        if (!rstn) begin
            held_ff <= 12'h000;
            delay_ff <= 4'h0;
            rxBits <= 12'hFFF;
            rxValid <= 1'b0;
        end else begin
            // Lines show garbage outside a strobe
            rxValid <= delay_ff == 4'h1;
            rxBits <= (delay_ff == 4'h1) ? held_ff : ~held_ff;
            if (txValid && !silent) begin
                held_ff <= txBits;
                delay_ff <= slow ? 4'h4 : 4'h1;
            end else if (delay_ff != 4'h0) begin
                delay_ff <= delay_ff - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// file: sim/test_line_diff_restraint_decision.sv
// Self-checking bench for the restraint and trip decision block
`timescale 1ns/1ps
`default_nettype none
`include "ldr_decision_map.vh"
module test_line_diff_restraint_decision;
    localparam int TC = 10;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [47:0] diffFundRe = '0, diffFundIm = '0, diffH2Re = '0, diffH2Im = '0;
    logic [47:0] diffH5Re = '0, diffH5Im = '0, localShiftedRe = '0, localShiftedIm = '0;
    logic [47:0] remoteShiftedRe = '0, remoteShiftedIm = '0;
    logic functionBlockInput = 1'b0;
    logic [11:0] txConfigBit = 12'h000;
    logic silent = 1'b0;
    logic slow = 1'b0;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, linkTxValid_ff, linkRxValid, generalTrip_ff, harmonicBlockFlag_ff;
    wire linkFailureFlag_ff, irq;
    wire [11:0] linkTxBits_ff, linkRxBits, rxConfigBit_ff;
    wire [2:0] phaseTrip_ff, harm2Restrain, harm5Restrain;
    logic [31:0] expQ [$];
    int compares = 0;
    int miscompares = 0;
    int cycles = 0;
    logic [5:0] regAdr [8] = '{`LDR_OFS_CTRL, `LDR_OFS_H2THR, `LDR_OFS_H5THR, `LDR_OFS_BASE,
        `LDR_OFS_SLOPE, `LDR_OFS_UNRLIM, `LDR_OFS_IRQMASK, 6'h2C};
    logic [31:0] regVal [8] = '{32'(`LDR_RST_CTRL), 32'(`LDR_RST_H2THR), 32'(`LDR_RST_H5THR),
        32'(`LDR_RST_BASE), 32'(`LDR_RST_SLOPE), 32'(`LDR_RST_UNRLIM), 32'h0, 32'h0};

    ldr_decision #(.TICK_CYCLES(TC)) i_dut (
        .clk_sys, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .diffFundRe, .diffFundIm, .diffH2Re, .diffH2Im, .diffH5Re, .diffH5Im,
        .localShiftedRe, .localShiftedIm, .remoteShiftedRe, .remoteShiftedIm,
        .functionBlockInput, .txConfigBit, .linkTxBits_ff, .linkTxValid_ff, .linkRxBits,
        .linkRxValid, .rxConfigBit_ff, .phaseTrip_ff, .generalTrip_ff, .harmonicBlockFlag_ff,
        .harm2Restrain, .harm5Restrain, .linkFailureFlag_ff, .irq
    );
    ldr_link_partner i_far (.clk_sys, .rstn, .txBits(linkTxBits_ff), .txValid(linkTxValid_ff),
        .silent, .slow, .rxBits(linkRxBits), .rxValid(linkRxValid));

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic wrap_up();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic cmpSig(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic cmpReg(input logic [31:0] got, input logic [31:0] exp);
        cmpSig(got, exp, "readdata");
    endtask
    // Read when wr is low; d is then the expected word
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        if (!wr) expQ.push_back(d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic ticks(input int n);
        repeat (n * TC) @(posedge clk_sys);
    endtask
    // ****************************************
    // Watchers
    // ****************************************
    always @(posedge clk_sys) begin
        if (avs_read && avs_waitrequest === 1'b0) cmpReg(avs_readdata, expQ.pop_front());
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            wrap_up();
        end
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        int n;
        void'($urandom(32'h9e22));
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        bus(1'b1, 6'h2C, 32'hFFFFFFFF);
        bus(1'b1, `LDR_OFS_STATUS, 32'h1FF);
        for (n = 0; n < 8; n++) bus(1'b0, regAdr[n], regVal[n]);
        bus(1'b0, `LDR_OFS_STATUS, 32'h0);
        diffFundRe[15:0] <= 16'd1000;
        diffH2Re[15:0] <= 16'd160 + 16'($urandom_range(240));
        ticks(2);
        @(negedge clk_sys);
        cmpSig(harm2Restrain, 3'b001, "h2 restrain");
        cmpSig(harm5Restrain, 3'b000, "h5 restrain");
        cmpSig(harmonicBlockFlag_ff, 1'b1, "harm block");
        ticks(3);
        // Exactly at threshold counts as low
        diffH2Re[15:0] <= 16'd150;
        ticks(2);
        @(negedge clk_sys);
        cmpSig(harm2Restrain, 3'b000, "short release");
        @(posedge clk_sys);
        diffFundRe[47:32] <= 16'd1000;
        diffH5Im[47:32] <= 16'd260;
        ticks(30);
        diffH5Im[47:32] <= 16'd250;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (harm5Restrain[2] === 1'b1 && n < 400);
        cmpSig(n > 14 * TC && n <= 16 * TC + 1, 1'b1, "stretch length");
        @(posedge clk_sys);
        diffFundRe <= 48'd5000;
        diffH5Im <= '0;
        ticks(2);
        @(negedge clk_sys);
        cmpSig(phaseTrip_ff, 3'b001, "restrained trip");
        cmpSig(generalTrip_ff, 1'b1, "general trip");
        bus(1'b1, `LDR_OFS_CTRL, 32'h0);
        ticks(1);
        cmpSig(phaseTrip_ff, 3'b000, "disabled");
        bus(1'b1, `LDR_OFS_CTRL, 32'h1);
        @(posedge clk_sys);
        remoteShiftedRe[47:32] <= 16'd20000;
        ticks(2);
        @(negedge clk_sys);
        cmpSig(phaseTrip_ff, 3'b000, "remote bias");
        @(posedge clk_sys);
        remoteShiftedRe <= '0;
        localShiftedIm[31:16] <= 16'hB1E0;
        ticks(2);
        @(negedge clk_sys);
        cmpSig(phaseTrip_ff, 3'b000, "local bias");
        @(posedge clk_sys);
        localShiftedIm <= '0;
        functionBlockInput <= 1'b1;
        ticks(2);
        @(negedge clk_sys);
        cmpSig(phaseTrip_ff, 3'b000, "user block");
        @(posedge clk_sys);
        functionBlockInput <= 1'b0;
        diffFundRe[15:0] <= 16'd30000;
        diffFundIm[15:0] <= 16'd30000;
        diffH2Re[15:0] <= 16'd10000;
        ticks(2);
        @(negedge clk_sys);
        cmpSig(phaseTrip_ff, 3'b001, "unrestrained trip");
        bus(1'b0, `LDR_OFS_STATUS, 32'h0B9);
        // Interrupt: trip and harmonic events latched, mask, clear
        bus(1'b0, `LDR_OFS_IRQSTAT, 32'h3);
        bus(1'b1, `LDR_OFS_IRQMASK, 32'h1);
        @(negedge clk_sys);
        cmpSig(irq, 1'b1, "irq masked in");
        bus(1'b1, `LDR_OFS_IRQSTAT, 32'h1);
        @(negedge clk_sys);
        cmpSig(irq, 1'b0, "irq cleared");
        bus(1'b0, `LDR_OFS_IRQSTAT, 32'h2);
        diffFundRe <= '0;
        diffFundIm <= '0;
        diffH2Re <= '0;
        txConfigBit <= 12'($urandom);
        slow <= 1'b1;
        ticks(3);
        bus(1'b0, `LDR_OFS_TXBITS, {20'h0, txConfigBit});
        bus(1'b0, `LDR_OFS_RXBITS, {20'h0, txConfigBit});
        @(negedge clk_sys);
        cmpSig(rxConfigBit_ff, txConfigBit, "rx bits");
        @(posedge clk_sys);
        silent <= 1'b1;
        ticks(22);
        @(negedge clk_sys);
        cmpSig(linkFailureFlag_ff, 1'b1, "link failure");
        bus(1'b0, `LDR_OFS_IRQSTAT, 32'h6);
        silent <= 1'b0;
        ticks(3);
        @(negedge clk_sys);
        cmpSig(linkFailureFlag_ff, 1'b0, "link restored");
        wrap_up();
    end
endmodule
`default_nettype wire
